// File: ias_pkg.sv
// Notes on behaviour
// - Register forms use two registers; immediate forms use a 16-bit immediate.
// - Trapping immediate word add: sign-extended immediate, 32-bit sum, trap on overflow.
// - Non-trapping immediate word add: same sum, never traps.
// - Immediate set-less-than, signed or unsigned, on sign-extended immediate; 1 or 0.
// - Immediate AND, OR, XOR use the zero-extended immediate.
// - Upper immediate load: immediate in bits 31:16, low half zero, sign-extended when mode64, else zero-extended.
// - Doubleword immediate adds give a 64-bit sum; only trapping form traps.
// - Register word adds give a 32-bit sum; trapping form traps on overflow.
// - Register word subtracts give a 32-bit difference; trapping form traps.
// - Register set-less-than, signed or unsigned, writes 1 or 0.
// - Doubleword register add gives 64-bit sum; trapping variant traps.
// - Doubleword register subtract gives 64-bit difference; trapping variant traps.
// - Logical word shifts by shift amount field fill zeros, 32-bit result.
// - Arithmetic right word shifts fill with the sign bit.
// - Variable word shifts use only the low five bits of operand A.
`default_nettype none
package ias_pkg;
	localparam int unsigned DATA_W  = 64;
	localparam int unsigned IMM_W   = 16;
	localparam int unsigned SHAMT_W = 5;
	localparam int unsigned REG_W   = 5;
	localparam logic [63:0] RESULT_RESET = 64'h0;

	typedef enum logic [4:0] {
		sum_imm_word_trapping,
		sum_imm_word_nontrapping,
		less_than_imm_signed_set,
		less_than_imm_unsigned_set,
		imm_bitwise_conjunction,
		imm_bitwise_disjunction,
		imm_bitwise_exclusive,
		upper_half_immediate_load,
		sum_imm_dword_trapping,
		sum_imm_dword_nontrapping,
		sum_word_trapping,
		sum_word_nontrapping,
		difference_word_trapping,
		difference_word_nontrapping,
		less_than_signed_set,
		less_than_unsigned_set,
		reg_bitwise_conjunction,
		reg_bitwise_disjunction,
		reg_bitwise_exclusive,
		reg_bitwise_nor,
		sum_dword_trapping,
		sum_dword_nontrapping,
		difference_dword_trapping,
		difference_dword_nontrapping,
		shift_left_zero_fill,
		shift_right_zero_fill,
		shift_right_sign_fill,
		shift_left_zero_fill_var,
		shift_right_zero_fill_var,
		shift_right_sign_fill_var
	} ias_op_t;

	typedef struct packed {
		logic              valid;
		ias_op_t           op;
		logic              mode64;
		logic [63:0]       operand_a_register;
		logic [63:0]       operand_b_register;
		logic [15:0]       immediate;
		logic [4:0]        shift_amount_field;
		logic [4:0]        dest;
	} ias_req_t;

	typedef struct packed {
		logic              wr_en;
		logic [4:0]        dest;
		logic [63:0]       data;
		logic              overflow;
	} ias_rsp_t;
endpackage
`default_nettype wire

// File: ias_alu.sv
`timescale 1ns/100ps
`default_nettype none
module ias_alu (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire ias_pkg::ias_req_t req,
	output var  ias_pkg::ias_rsp_t rsp
);
	typedef struct packed {
		ias_pkg::ias_rsp_t rsp;
	} ias_state_t;

	ias_state_t state_reg;
	ias_state_t state_next;

	logic [63:0] a;
	logic [63:0] b;
	logic [63:0] simm;
	logic [63:0] zimm;
	logic [31:0] w;
	logic [63:0] d;
	logic [4:0]  sh;
	logic        word_res;
	logic        trap;
	logic        ovf;
	logic [63:0] res;

	always_comb
	begin
		a = req.operand_a_register;
		b = req.operand_b_register;
		simm = {{48{req.immediate[15]}}, req.immediate};
		zimm = {48'h0, req.immediate};
		w = 32'h0;
		d = 64'h0;
		res = 64'h0;
		word_res = 1'b0;
		trap = 1'b0;
		ovf = 1'b0;
		sh = req.shift_amount_field;
		unique case (req.op)
			ias_pkg::shift_left_zero_fill_var,
			ias_pkg::shift_right_zero_fill_var,
			ias_pkg::shift_right_sign_fill_var: sh = a[4:0];
			default: sh = req.shift_amount_field;
		endcase
		unique case (req.op)
			ias_pkg::sum_imm_word_trapping, ias_pkg::sum_imm_word_nontrapping:
			begin
				w = a[31:0] + simm[31:0];
				word_res = 1'b1;
				trap = (req.op == ias_pkg::sum_imm_word_trapping);
				ovf = (a[31] == simm[31]) && (w[31] != a[31]);
			end
			ias_pkg::less_than_imm_signed_set:
				res = {63'h0, $signed(a) < $signed(simm)};
			ias_pkg::less_than_imm_unsigned_set:
				res = {63'h0, a < simm};
			ias_pkg::imm_bitwise_conjunction: res = a & zimm;
			ias_pkg::imm_bitwise_disjunction: res = a | zimm;
			ias_pkg::imm_bitwise_exclusive:   res = a ^ zimm;
			ias_pkg::upper_half_immediate_load:
			begin
				w = {req.immediate, 16'h0};
				word_res = 1'b1;
			end
			ias_pkg::sum_imm_dword_trapping, ias_pkg::sum_imm_dword_nontrapping:
			begin
				d = a + simm;
				res = d;
				trap = (req.op == ias_pkg::sum_imm_dword_trapping);
				ovf = (a[63] == simm[63]) && (d[63] != a[63]);
			end
			ias_pkg::sum_word_trapping, ias_pkg::sum_word_nontrapping:
			begin
				w = a[31:0] + b[31:0];
				word_res = 1'b1;
				trap = (req.op == ias_pkg::sum_word_trapping);
				ovf = (a[31] == b[31]) && (w[31] != a[31]);
			end
			ias_pkg::difference_word_trapping, ias_pkg::difference_word_nontrapping:
			begin
				w = a[31:0] - b[31:0];
				word_res = 1'b1;
				trap = (req.op == ias_pkg::difference_word_trapping);
				ovf = (a[31] != b[31]) && (w[31] != a[31]);
			end
			ias_pkg::less_than_signed_set:
				res = {63'h0, $signed(a) < $signed(b)};
			ias_pkg::less_than_unsigned_set:
				res = {63'h0, a < b};
			ias_pkg::reg_bitwise_conjunction: res = a & b;
			ias_pkg::reg_bitwise_disjunction: res = a | b;
			ias_pkg::reg_bitwise_exclusive:   res = a ^ b;
			ias_pkg::reg_bitwise_nor:         res = ~(a | b);
			ias_pkg::sum_dword_trapping, ias_pkg::sum_dword_nontrapping:
			begin
				d = a + b;
				res = d;
				trap = (req.op == ias_pkg::sum_dword_trapping);
				ovf = (a[63] == b[63]) && (d[63] != a[63]);
			end
			ias_pkg::difference_dword_trapping, ias_pkg::difference_dword_nontrapping:
			begin
				d = a - b;
				res = d;
				trap = (req.op == ias_pkg::difference_dword_trapping);
				ovf = (a[63] != b[63]) && (d[63] != a[63]);
			end
			ias_pkg::shift_left_zero_fill, ias_pkg::shift_left_zero_fill_var:
			begin
				w = b[31:0] << sh;
				word_res = 1'b1;
			end
			ias_pkg::shift_right_zero_fill, ias_pkg::shift_right_zero_fill_var:
			begin
				w = b[31:0] >> sh;
				word_res = 1'b1;
			end
			ias_pkg::shift_right_sign_fill, ias_pkg::shift_right_sign_fill_var:
			begin
				w = $unsigned($signed(b[31:0]) >>> sh);
				word_res = 1'b1;
			end
			default: res = 64'h0;
		endcase
		if (word_res)
			res = req.mode64 ? {{32{w[31]}}, w} : {32'h0, w};
		state_next = state_reg;
		state_next.rsp.overflow = req.valid && trap && ovf;
		state_next.rsp.wr_en = req.valid && !(trap && ovf);
		state_next.rsp.dest = req.dest;
		if (req.valid)
			state_next.rsp.data = res;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			state_reg.rsp.wr_en <= 1'b0;
			state_reg.rsp.dest <= 5'h0;
			state_reg.rsp.data <= ias_pkg::RESULT_RESET;
			state_reg.rsp.overflow <= 1'b0;
		end
		else
			state_reg <= state_next;
	end

	assign rsp = state_reg.rsp;
endmodule // ias_alu
`default_nettype wire

// File: ias_alu_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ias_alu_sva (
	input wire logic              core_clk,
	input wire logic              rstn,
	input wire ias_pkg::ias_req_t req,
	input wire ias_pkg::ias_rsp_t rsp
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	one_answer_a: assert property (
		req.valid |=> rsp.wr_en != rsp.overflow) else $error("not one answer");
	idle_quiet_a: assert property (
		!req.valid |=> !rsp.wr_en && !rsp.overflow) else $error("answer unasked");
	dest_follow_a: assert property (
		req.valid |=> rsp.dest == $past(req.dest)) else $error("wrong dest");
	never_trap_a: assert property (
		req.valid && req.op == ias_pkg::sum_word_nontrapping |=> rsp.wr_en)
		else $error("nontrapping add trapped");
	unsigned_set_a: assert property (
		req.valid && req.op == ias_pkg::less_than_unsigned_set |=> rsp.data ==
		{63'h0, $past(req.operand_a_register) < $past(req.operand_b_register)})
		else $error("bad unsigned set");
	nor_result_a: assert property (
		req.valid && req.op == ias_pkg::reg_bitwise_nor |=> rsp.data ==
		~($past(req.operand_a_register) | $past(req.operand_b_register))) else $error("bad nor");
	upper_load_a: assert property (
		req.valid && req.op == ias_pkg::upper_half_immediate_load && req.mode64 |=>
		rsp.data[15:0] == 16'h0 && rsp.data[31:16] == $past(req.immediate)
		&& rsp.data[63:32] == {32{rsp.data[31]}}) else $error("bad upper load");
	var_shift_a: assert property (
		req.valid && req.op == ias_pkg::shift_left_zero_fill_var |=> rsp.data[31:0] ==
		32'($past(req.operand_b_register) << $past(req.operand_a_register[4:0])))
		else $error("bad variable shift");
endmodule // ias_alu_sva
bind ias_alu ias_alu_sva chk (.core_clk(core_clk), .rstn(rstn), .req(req), .rsp(rsp));
`default_nettype wire

// File: ias_regfile.sv
`timescale 1ns/100ps
`default_nettype none
module ias_regfile (
	input wire logic              core_clk,
	input wire ias_pkg::ias_rsp_t rsp
);
	logic [63:0] mem [32];
	initial mem = '{default: 64'h0};
	always @(posedge core_clk)
		if (rsp.wr_en)
			mem[rsp.dest] <= rsp.data;
endmodule // ias_regfile
`default_nettype wire

// File: integer_alu_shift_datapath_tb.sv
`timescale 1ns/100ps
`default_nettype none
module integer_alu_shift_datapath_tb;
	logic              core_clk;
	logic              rstn;
	ias_pkg::ias_req_t req;
	ias_pkg::ias_rsp_t rsp;
	logic [63:0]       shadow [32];
	logic [64:0]       e;
	int                n_mismatch;
	int                samples_checked;
	ias_alu DUT (.core_clk(core_clk), .rstn(rstn), .req(req), .rsp(rsp));
	ias_regfile rf (.core_clk(core_clk), .rsp(rsp));
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic report_and_stop();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [63:0] sx(input logic [63:0] v);
		return {{32{v[31]}}, v[31:0]};
	endfunction
	// Corner values make overflow frequent
	function automatic logic [63:0] pick();
		case ($urandom % 4)
			0: return 64'h7fffffff;
			1: return 64'h8000000000000000;
			default: return {$urandom, $urandom};
		endcase
	endfunction
	// Ops by enum position; returns {trap, data}
	function automatic logic [64:0] mdl(input ias_pkg::ias_req_t r);
		logic [63:0] a;
		logic [63:0] b;
		logic [63:0] y;
		logic [4:0]  sh;
		logic        o;
		logic        n;
		int          k;
		a = r.operand_a_register;
		b = r.operand_b_register;
		k = int'(r.op);
		o = 1'b0;
		n = k inside {12, 13, 22, 23};
		sh = k > 26 ? a[4:0] : r.shift_amount_field;
		if (k < 10 && k != 7)
			b = k inside {[4:6]} ? {48'h0, r.immediate} : {{48{r.immediate[15]}}, r.immediate};
		b = n ? ~b : b;
		y = a + b + 64'(n);
		case (k)
			0, 1, 10, 11, 12, 13: o = a[31] == b[31] && y[31] != a[31];
			8, 9, 20, 21, 22, 23: o = a[63] == b[63] && y[63] != a[63];
			2, 14: y = 64'($signed(a) < $signed(b));
			3, 15: y = 64'(a < b);
			4, 16: y = a & b;
			5, 17: y = a | b;
			6, 18: y = a ^ b;
			19: y = ~(a | b);
			7: y = {32'h0, r.immediate, 16'h0};
			24, 27: y = 64'(b[31:0] << sh);
			25, 28: y = 64'(b[31:0] >> sh);
			default: y = 64'($signed(b[31:0]) >>> sh);
		endcase
		if (k inside {0, 1, 7, [10:13], [24:29]})
			y = r.mode64 ? sx(y) : {32'h0, y[31:0]};
		return {o && k inside {0, 8, 10, 12, 20, 22}, y};
	endfunction
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		#20000;
		n_mismatch++;
		report_and_stop();
	end
	initial
	begin
		n_mismatch = 0;
		samples_checked = 0;
		shadow = '{default: 64'h0};
		rstn = 1'b0;
		req = '0;
		void'($urandom(32'hfe80e2e8));
		repeat (12) @(negedge core_clk);
		check(rsp.data, 64'h0);
		check({rsp.wr_en, rsp.overflow}, 0);
		for (int i = 0; i < 1000; i++)
		begin
			// Reset lands mid-stream with a request pending
			rstn = !(i inside {600, 601});
			req.valid = $urandom % 8 != 0;
			req.op = ias_pkg::ias_op_t'(i % 30);
			req.mode64 = 1'($urandom);
			req.operand_a_register = req.mode64 ? sx(pick()) : pick();
			req.operand_b_register = req.mode64 ? sx(pick()) : pick();
			req.immediate = 16'($urandom);
			req.shift_amount_field = 5'($urandom);
			req.dest = 5'($urandom);
			e = mdl(req);
			@(negedge core_clk);
			if (!rstn)
				check(rsp.data, 64'h0);
			if (!rstn || !req.valid)
				check({rsp.wr_en, rsp.overflow}, 0);
			else
			begin
				check({rsp.overflow, rsp.wr_en}, {e[64], !e[64]});
				check(rsp.dest, req.dest);
				if (!e[64])
				begin
					check(rsp.data, e[63:0]);
					shadow[req.dest] = e[63:0];
				end
			end
		end
		rstn = 1'b1;
		req.valid = 1'b0;
		repeat (2) @(negedge core_clk);
		for (int i = 0; i < 32; i++)
			check(rf.mem[i], shadow[i]);
		report_and_stop();
	end
endmodule // integer_alu_shift_datapath_tb
`default_nettype wire
